//--- tb_extended_set_indexed_offset_decode.sv
// tb_extended_set_indexed_offset_decode: self-checking bench for xsd_decode
`timescale 1ns/1ns
module tb_extended_set_indexed_offset_decode;
  import xsd_pkg::*;
  // --------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------
  logic clk = 0, rst_n = 0, xen = 1, iv = 0, sv = 0, sa = 0, sd = 0, pw = 0;
  logic [IW-1:0]  ins = 0;
  logic [7:0]     sf  = 0;
  logic [3:0]     bank_select_register = 0;
  logic [1:0]     ps  = 0;
  logic [AW-1:0]  pwd = 0, p0, p1, p2, saddr, maddr;
  logic [PCW-1:0] return_stack_top = 0, pcv;
  logic [DW-1:0]  rdat, wdat;
  logic           act, rdy, svo, sdf, six, re, we, pcl;
  logic [31:0]    lf, e;
  int             bad_count = 0, checks_done = 0, m[3], k, s, i;

  always #2 clk = ~clk;

  xsd_decode DUT (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_extended_set_enable_bit(xen), .o_ext_active(act),
    .i_instr_valid(iv), .i_instr(ins), .o_instr_ready(rdy),
    .i_std_valid(sv), .i_std_file(sf), .i_std_access(sa), .i_std_dest(sd),
    .i_bank_select_register(bank_select_register), .o_std_valid(svo), .o_std_addr(saddr),
    .o_std_dest_file(sdf), .o_std_indexed(six), .i_ptr_wr(pw),
    .i_ptr_sel(ps), .i_ptr_wdata(pwd), .o_file_select_pointer0(p0),
    .o_file_select_pointer1(p1), .o_software_stack_pointer(p2),
    .o_mem_addr(maddr), .o_mem_re(re), .o_mem_we(we), .o_mem_wdata(wdat),
    .i_mem_rdata(rdat), .i_return_stack_top(return_stack_top), .o_pc_load(pcl),
    .o_pc_value(pcv));

  xsd_mem_model u_mem (.i_clk_sys(clk), .i_addr(maddr), .i_re(re),
    .o_rdata(rdat));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, g);
    end
  endtask : chk

  task chk_ptrs;
    chk("ptr0", m[0], p0);
    chk("ptr1", m[1], p1);
    chk("ptr2", m[2], p2);
  endtask : chk_ptrs

  // reset with a chosen enable bit; edge 1 after release captures it
  task reset_dut(input logic en);
    @(posedge clk);
    rst_n <= 0;
    xen   <= en;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    m = '{0, 0, 0};
    @(posedge clk);
    #1;
  endtask : reset_dut

  // word held until a rising edge sees ready high, bounded
  task issue(input logic [IW-1:0] w);
    int n;
    n = 0;
    @(posedge clk);
    iv  <= 1;
    ins <= w;
    #1;
    while (rdy !== 1'b1) begin
      n++;
      if (n > 8) begin
        bad_count++;
        tally_and_finish;
      end
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    iv <= 0;
    #1;
  endtask : issue

  task pwr(input logic [1:0] sel, input logic [AW-1:0] v);
    @(posedge clk);
    pw  <= 1;
    ps  <= sel;
    pwd <= v;
    @(posedge clk);
    pw <= 0;
    #1;
    m[sel] = v;
  endtask : pwr

  // standard operand request, compared with the access-bank model
  task std_req(input logic [7:0] f, input logic a, input logic d);
    logic [AW-1:0] x;
    logic          ix;
    @(posedge clk);
    sv  <= 1;
    sf  <= f;
    sa  <= a;
    sd  <= d;
    bank_select_register <= 4'(rnd());
    @(posedge clk);
    sv <= 0;
    #1;
    ix = 0;
    if (a) begin
      x = {bank_select_register, f};
    end else if (xen && f <= 8'h5F) begin
      x  = 12'(m[2] + f);
      ix = 1;
    end else if (f < 8'h60) begin
      x = {4'h0, f};
    end else begin
      x = {4'hF, f};
    end
    chk("std_valid", 1, svo);
    chk("std_addr", x, saddr);
    chk("std_dest", d, sdf);
    chk("std_indexed", ix, six);
  endtask : std_req

  // move of two indexed words; src/dst offsets from the stack pointer;
  // gap idles between the words so the held byte path is exercised too
  task move(input logic [6:0] zs, input logic [6:0] zd, input int gap);
    logic [AW-1:0] sa_, da_;
    logic [7:0]    b;
    sa_ = 12'(m[2] + zs);
    da_ = 12'(m[2] + zd);
    issue({8'hEB, 1'b1, zs});
    s = (sa_ >= 12'hFDB && sa_ <= 12'hFDF) || (sa_ >= 12'hFE3 &&
         sa_ <= 12'hFE7) || (sa_ >= 12'hFEB && sa_ <= 12'hFEF);
    b = s ? 8'h00 : sa_[7:0] ^ {sa_[11:8], 4'hA};
    chk("mv_re", !s, re);
    if (!s) chk("mv_raddr", sa_, maddr);
    repeat (gap) @(posedge clk);
    issue({9'h1E0, zd});
    s = (da_ >= 12'hFDB && da_ <= 12'hFDF) || (da_ >= 12'hFE3 &&
         da_ <= 12'hFE7) || (da_ >= 12'hFEB && da_ <= 12'hFEF);
    chk("mv_we", !s, we);
    if (!s) chk("mv_waddr", da_, maddr);
    if (!s) chk("mv_wdata", b, wdat);
  endtask : move

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    lf = 32'h6380983D;
    reset_dut(1);
    chk("ext_active", 1, act);
    // push literal, then push across address zero
    pwr(2, 12'h1EC);
    issue(16'hFA08);
    chk("push_we", 1, we);
    chk("push_addr", 12'h1EC, maddr);
    chk("push_data", 8'h08, wdat);
    m[2] = 12'h1EB;
    chk_ptrs;
    pwr(2, 12'h000);
    issue(16'hFA7E);
    chk("push_addr0", 0, maddr);
    m[2] = 12'hFFF;
    chk_ptrs;
    // subtract from each selectable pointer, random values
    for (i = 0; i < 12; i++) begin
      k = rnd() % 64;
      pwr(2'(i % 3), 12'(rnd()));
      issue({8'hE9, 2'(i % 3), 6'(k)});
      m[i % 3] = (m[i % 3] - k) & 12'hFFF;
      chk_ptrs;
      chk("sub_no_pc", 0, pcl);
    end
    // subtract-and-return: pc load, then one dead cycle
    pwr(2, 12'(rnd()));
    @(posedge clk);
    return_stack_top <= 21'(rnd());
    k = rnd() % 64;
    issue({8'hE9, 2'b11, 6'(k)});
    m[2] = (m[2] - k) & 12'hFFF;
    chk("ret_pcl", 1, pcl);
    chk("ret_pcv", return_stack_top, pcv);
    chk("ret_busy", 0, rdy);
    chk_ptrs;
    @(posedge clk);
    #1;
    chk("ret_pcl_end", 0, pcl);
    chk("ret_ready", 1, rdy);
    // moves: plain, indirect source, indirect destination
    pwr(2, 12'h080);
    move(7'h05, 7'h06, 0);
    move(7'h10, 7'h11, 3);
    // first word without the indexed bit is refused outright
    issue({8'hEB, 8'h05});
    chk("mv_bit7_off", 0, re);
    chk("mv_bit7_rdy", 1, rdy);
    pwr(2, 12'hFE0);
    move(7'h0C, 7'h00, 0);
    move(7'h00, 7'h0D, 2);
    chk_ptrs;
    // standard operands, boundaries first, zero pointer every fifth
    for (i = 0; i < 30; i++) begin
      pwr(2, (i % 5 == 0) ? 12'h000 : 12'(rnd()));
      e = rnd();
      std_req(i == 0 ? 8'h5F : i == 1 ? 8'h60 : e[7:0], i > 3 && e[8], e[9]);
    end
    // extended set off: words refused, operands literal
    reset_dut(0);
    chk("ext_off", 0, act);
    pwr(2, 12'h300);
    issue(16'hFA55);
    chk("off_push_we", 0, we);
    chk_ptrs;
    for (i = 0; i < 8; i++) begin
      e = rnd();
      std_req(i == 0 ? 8'h10 : e[7:0], e[8], e[9]);
    end
    tally_and_finish;
  end
endmodule : tb_extended_set_indexed_offset_decode

//--- xsd_decode.sv
// xsd_decode: extended-set instruction tail and indexed operand decode
//
// Overview of operation
// - push literal: store at pointer, decrement
// - subtract literal from selected pointer, one cycle
// - selector three: subtract from stack, then return
// - subtract-and-return takes two cycles, second idle
// - indexed move: read source, then write destination
// - extended set also enables indexed operand mode
// - set off: operand addresses are literal locations
// - set on, access low: operand offsets stack pointer
// - operands above limit keep access-bank meaning
// - only access-select operands up to 5Fh are reinterpreted
// - destination bit keeps its usual meaning
// - zero stack pointer gives original access mapping
// - configuration bit one enables; zero disables
// - indirect destination turns move into no-op
// - indirect source reads zero, no access made
`timescale 1ns/1ns
module xsd_decode
  import xsd_pkg::*;
(
  // clock and reset
  input  wire logic           i_clk_sys,
  input  wire logic           i_reset_n,
  // configuration
  input  wire logic           i_extended_set_enable_bit,
  output logic                o_ext_active,
  // instruction words from fetch
  input  wire logic           i_instr_valid,
  input  wire logic [IW-1:0]  i_instr,
  output logic                o_instr_ready,
  // standard operand resolution
  input  wire logic           i_std_valid,
  input  wire logic [7:0]     i_std_file,
  input  wire logic           i_std_access,
  input  wire logic           i_std_dest,
  input  wire logic [3:0]     i_bank_select_register,
  output logic                o_std_valid,
  output logic [AW-1:0]       o_std_addr,
  output logic                o_std_dest_file,
  output logic                o_std_indexed,
  // pointer register write port and views
  input  wire logic           i_ptr_wr,
  input  wire logic [1:0]     i_ptr_sel,
  input  wire logic [AW-1:0]  i_ptr_wdata,
  output logic [AW-1:0]       o_file_select_pointer0,
  output logic [AW-1:0]       o_file_select_pointer1,
  output logic [AW-1:0]       o_software_stack_pointer,
  // data memory port
  output logic [AW-1:0]       o_mem_addr,
  output logic                o_mem_re,
  output logic                o_mem_we,
  output logic [DW-1:0]       o_mem_wdata,
  input  wire logic [DW-1:0]  i_mem_rdata,
  // return stack
  input  wire logic [PCW-1:0] i_return_stack_top,
  output logic                o_pc_load,
  output logic [PCW-1:0]      o_pc_value
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // base plus a small offset, wrapping in the address space
  function automatic logic [AW-1:0] ofs_addr(input logic [AW-1:0] base,
                                             input logic [7:0]    ofs);
    ofs_addr = base + {4'h0, ofs};
  endfunction : ofs_addr
  // true when an address falls on an indirect addressing register
  function automatic logic is_ind(input logic [AW-1:0] a);
    is_ind = ((a <= IND_TOP0) && (a >= IND_TOP0 - IND_SPAN)) ||
             ((a <= IND_TOP1) && (a >= IND_TOP1 - IND_SPAN)) ||
             ((a <= IND_TOP2) && (a >= IND_TOP2 - IND_SPAN));
  endfunction : is_ind
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  xsd_state_t       state_q,     state_d;      // sequencer
  logic [AW-1:0]    ptr_q [NPTR];              // pointer registers
  logic [AW-1:0]    ptr_d [NPTR];
  logic             ext_en_q,    ext_en_d;     // captured config bit
  logic             cfg_ld_q,    cfg_ld_d;     // config captured once
  logic             src_ind_q,   src_ind_d;    // source was indirect
  logic [DW-1:0]    mv_data_q,   mv_data_d;    // held move byte
  logic [AW-1:0]    mem_addr_q,  mem_addr_d;
  logic             mem_re_q,    mem_re_d;
  logic             mem_we_q,    mem_we_d;
  logic [DW-1:0]    mem_wdat_q,  mem_wdat_d;
  logic             pc_load_q,   pc_load_d;
  logic [PCW-1:0]   pc_val_q,    pc_val_d;
  logic             std_vld_q,   std_vld_d;
  logic [AW-1:0]    std_addr_q,  std_addr_d;
  logic             std_dest_q,  std_dest_d;
  logic             std_idx_q,   std_idx_d;
  logic [7:0]       op_hi;        // opcode byte of the current word
  logic [1:0]       sub_sel;      // pointer selector field
  logic [7:0]       sub_k;        // 6-bit literal, zero extended
  logic [AW-1:0]    sp;           // current stack pointer
  logic             take_w2;      // second move word taken this cycle
  logic [AW-1:0]    dst_addr;     // computed move destination
  logic [DW-1:0]    fresh_data;   // source byte as it arrives
  assign op_hi      = i_instr[15:8];
  assign sub_sel    = i_instr[7:6];
  assign sub_k      = {2'h0, i_instr[5:0]};
  assign sp         = ptr_q[SP_INDEX];
  assign fresh_data = src_ind_q ? IND_RD_VAL : i_mem_rdata;
  assign dst_addr   = ofs_addr(sp, {1'b0, i_instr[6:0]});
  assign take_w2    = i_instr_valid &&
                      ((state_q == ST_MV_CAP) || (state_q == ST_MV_W2));
  // ready is combinational: busy only while the read is in flight or
  // during the dead cycle of the return form
  assign o_instr_ready = (state_q == ST_IDLE) || (state_q == ST_MV_CAP) ||
                         (state_q == ST_MV_W2);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    ptr_d      = ptr_q;
    ext_en_d   = ext_en_q;
    cfg_ld_d   = 1'b1;
    src_ind_d  = src_ind_q;
    mv_data_d  = mv_data_q;
    mem_addr_d = mem_addr_q;
    mem_re_d   = 1'b0;
    mem_we_d   = 1'b0;
    mem_wdat_d = mem_wdat_q;
    pc_load_d  = 1'b0;
    pc_val_d   = pc_val_q;
    // the enable bit is caught once after reset and then held
    if (!cfg_ld_q) begin
      ext_en_d = i_extended_set_enable_bit;
    end
    // core writes to pointers; an instruction in the same cycle wins
    if (i_ptr_wr && (i_ptr_sel != SEL_RETURN)) begin
      ptr_d[i_ptr_sel] = i_ptr_wdata;
    end
    // standard operand resolution, one result per request
    std_vld_d  = i_std_valid;
    std_dest_d = std_dest_q;
    std_addr_d = std_addr_q;
    std_idx_d  = std_idx_q;
    if (i_std_valid) begin
      std_dest_d = i_std_dest;
      std_idx_d  = 1'b0;
      if (i_std_access) begin
        // banked: bank select register supplies the high nibble
        std_addr_d = {i_bank_select_register, i_std_file};
      end else if (ext_en_q && (i_std_file <= OFS_MAX)) begin
        // any access-low operand in range becomes a stack offset
        std_addr_d = ofs_addr(sp, i_std_file);
        std_idx_d  = 1'b1;
      end else if (i_std_file < ACC_SPLIT) begin
        std_addr_d = {ACC_LO_BANK, i_std_file};
      end else begin
        std_addr_d = {ACC_HI_BANK, i_std_file};
      end
    end
    case (state_q)
      ST_IDLE: begin
        // extended opcodes exist only with the set enabled
        if (i_instr_valid && ext_en_q) begin
          if (op_hi == OP_PUSH_LIT) begin
            mem_addr_d     = sp;
            mem_wdat_d     = i_instr[7:0];
            mem_we_d       = 1'b1;
            ptr_d[SP_INDEX] = sp - 12'h001;
          end else if (op_hi == OP_SUB_PTR) begin
            if (sub_sel == SEL_RETURN) begin
              ptr_d[SP_INDEX] = sp - {4'h0, sub_k};
              pc_load_d       = 1'b1;
              pc_val_d        = i_return_stack_top;
              state_d         = ST_RET_NOP;
            end else begin
              ptr_d[sub_sel] = ptr_q[sub_sel] - {4'h0, sub_k};
            end
          end else if ((op_hi == OP_MOVE_IDX) && i_instr[MOVE_SEL_BIT]) begin
            // no read at all when the source is indirect
            mem_addr_d = ofs_addr(sp, {1'b0, i_instr[6:0]});
            src_ind_d  = is_ind(mem_addr_d);
            mem_re_d   = !src_ind_d;
            state_d    = ST_MV_RD;
          end
        end
      end
      ST_MV_RD: begin
        // memory answers in the next cycle
        state_d = ST_MV_CAP;
      end
      ST_MV_CAP: begin
        // read data stands only now, so keep it
        mv_data_d = fresh_data;
        state_d   = ST_MV_W2;
      end
      ST_MV_W2: begin
        // hold the byte until the second word arrives
        state_d = ST_MV_W2;
      end
      ST_RET_NOP: begin
        // dead cycle while the return target is fetched
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // second move word: compute destination and write it unless it is indirect
    if (take_w2) begin
      state_d = ST_IDLE;
      if (!is_ind(dst_addr)) begin
        mem_addr_d = dst_addr;
        mem_we_d   = 1'b1;
        mem_wdat_d = (state_q == ST_MV_CAP) ? fresh_data : mv_data_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= ST_IDLE;
      for (int i = 0; i < NPTR; i++) begin
        ptr_q[i] <= PTR_RST;
      end
      ext_en_q   <= 1'b0;
      cfg_ld_q   <= 1'b0;
      src_ind_q  <= 1'b0;
      mv_data_q  <= DAT_RST;
      mem_addr_q <= PTR_RST;
      mem_re_q   <= 1'b0;
      mem_we_q   <= 1'b0;
      mem_wdat_q <= DAT_RST;
      pc_load_q  <= 1'b0;
      pc_val_q   <= PC_RST;
      std_vld_q  <= 1'b0;
      std_addr_q <= PTR_RST;
      std_dest_q <= 1'b0;
      std_idx_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      ptr_q      <= ptr_d;
      ext_en_q   <= ext_en_d;
      cfg_ld_q   <= cfg_ld_d;
      src_ind_q  <= src_ind_d;
      mv_data_q  <= mv_data_d;
      mem_addr_q <= mem_addr_d;
      mem_re_q   <= mem_re_d;
      mem_we_q   <= mem_we_d;
      mem_wdat_q <= mem_wdat_d;
      pc_load_q  <= pc_load_d;
      pc_val_q   <= pc_val_d;
      std_vld_q  <= std_vld_d;
      std_addr_q <= std_addr_d;
      std_dest_q <= std_dest_d;
      std_idx_q  <= std_idx_d;
    end
  end

  // outputs, all from flip-flops
  assign o_ext_active             = ext_en_q;
  assign o_std_valid              = std_vld_q;
  assign o_std_addr               = std_addr_q;
  assign o_std_dest_file          = std_dest_q;
  assign o_std_indexed            = std_idx_q;
  assign o_file_select_pointer0   = ptr_q[0];
  assign o_file_select_pointer1   = ptr_q[1];
  assign o_software_stack_pointer = ptr_q[SP_INDEX];
  assign o_mem_addr               = mem_addr_q;
  assign o_mem_re                 = mem_re_q;
  assign o_mem_we                 = mem_we_q;
  assign o_mem_wdata              = mem_wdat_q;
  assign o_pc_load                = pc_load_q;
  assign o_pc_value               = pc_val_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  logic go;  // an extended first word is taken this cycle
  assign go = (state_q == ST_IDLE) && i_instr_valid && ext_en_q;

  sequence s_ret_issue;
    o_pc_load && (o_pc_value == $past(i_return_stack_top));
  endsequence
  sequence s_ret_idle;
    !o_instr_ready && !o_mem_we ##1 o_instr_ready;
  endsequence

  AST_PUSH_WRITE: assert property (go && op_hi == OP_PUSH_LIT |=>
    o_mem_we && o_mem_addr == $past(sp) && o_mem_wdata == $past(i_instr[7:0]))
    else $error("push did not write literal at stack pointer");
  AST_PUSH_DEC: assert property (go && op_hi == OP_PUSH_LIT |=>
    o_software_stack_pointer == $past(sp) - 12'h001)
    else $error("push did not decrement stack pointer");
  AST_SUB_PTR: assert property (go && op_hi == OP_SUB_PTR &&
    sub_sel != SEL_RETURN |=>
    ptr_q[$past(sub_sel)] == $past(ptr_q[sub_sel]) - $past({4'h0, sub_k}))
    else $error("pointer subtract result wrong");
  AST_SUB_RET: assert property (go && op_hi == OP_SUB_PTR &&
    sub_sel == SEL_RETURN |=> s_ret_issue and
    (o_software_stack_pointer == $past(sp) - $past({4'h0, sub_k})))
    else $error("subtract and return wrong");
  AST_RET_TWO: assert property (go && op_hi == OP_SUB_PTR &&
    sub_sel == SEL_RETURN |=> s_ret_idle)
    else $error("return form not two cycles");
  AST_MOVE_SEQ: assert property (go && op_hi == OP_MOVE_IDX &&
    i_instr[MOVE_SEL_BIT] |=> !o_instr_ready ##1 o_instr_ready)
    else $error("move did not read then wait for second word");
  AST_EXT_GATE: assert property (!ext_en_q && i_instr_valid &&
    state_q == ST_IDLE |=> !o_mem_we && !o_mem_re && !o_pc_load)
    else $error("extended opcode acted while disabled");
  AST_LITERAL: assert property (!ext_en_q && i_std_valid &&
    !i_std_access && i_std_file < ACC_SPLIT |=>
    o_std_addr == {ACC_LO_BANK, $past(i_std_file)} && !o_std_indexed)
    else $error("literal access address wrong");
  AST_INDEXED: assert property (ext_en_q && i_std_valid &&
    !i_std_access && i_std_file <= OFS_MAX |=>
    o_std_indexed && o_std_addr == $past(sp) + $past({4'h0, i_std_file}))
    else $error("indexed operand address wrong");
  AST_HIGH_ACC: assert property (ext_en_q && i_std_valid &&
    !i_std_access && i_std_file > OFS_MAX |=>
    o_std_addr == {ACC_HI_BANK, $past(i_std_file)})
    else $error("high access operand reinterpreted");
  AST_DEST_BIT: assert property (i_std_valid |=>
    o_std_valid && o_std_dest_file == $past(i_std_dest))
    else $error("destination bit not kept");
  AST_IND_DST: assert property (take_w2 && is_ind(dst_addr) |=>
    !o_mem_we)
    else $error("move wrote an indirect register");
  AST_IND_SRC: assert property (o_mem_re |-> !is_ind(o_mem_addr))
    else $error("indirect register read by move");

endmodule : xsd_decode

//--- xsd_mem_model.sv
// xsd_mem_model: data memory stand-in that answers the decode block's reads
`timescale 1ns/1ns
module xsd_mem_model
  import xsd_pkg::*;
(
  // clock
  input  wire logic          i_clk_sys,
  // read request from the block
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_re,
  // read data, valid only in the cycle after i_re
  output logic [DW-1:0]      o_rdata
);
  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  // contents are a fixed scramble of the address; outside a read the
  // line toggles, so a sample one cycle late sees the byte inverted
  initial o_rdata = 8'h5A;
  always @(posedge i_clk_sys) begin
    if (i_re) begin
      o_rdata <= i_addr[7:0] ^ {i_addr[11:8], 4'hA};
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule : xsd_mem_model

//--- xsd_pkg.sv
// xsd_pkg: constants and types for the extended-set indexed decode block
package xsd_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int AW   = 12;               // data address width
  localparam int DW   = 8;                // data byte width
  localparam int IW   = 16;               // instruction word width
  localparam int PCW  = 21;               // program counter width
  localparam int NPTR = 3;                // number of pointer registers

  // ----------------------------------------------------------------------
  // opcode fields (upper byte of the first word)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_PUSH_LIT  = 8'hFA; // push literal
  localparam logic [7:0] OP_SUB_PTR   = 8'hE9; // subtract from pointer
  localparam logic [7:0] OP_MOVE_IDX  = 8'hEB; // indexed move, first word
  localparam int         MOVE_SEL_BIT = 7;     // 1: indexed move, first word
  localparam logic [1:0] SEL_RETURN   = 2'h3;  // selector for the return form
  localparam logic [1:0] SP_INDEX     = 2'h2;  // stack pointer slot

  // ----------------------------------------------------------------------
  // access bank layout
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_MAX     = 8'h5F;   // largest indexed operand
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;   // low/high access split
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;    // low half of access bank
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;    // high half of access bank

  // ----------------------------------------------------------------------
  // indirect addressing register windows (top address, span below it)
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] IND_TOP0   = 12'hFEF;
  localparam logic [AW-1:0] IND_TOP1   = 12'hFE7;
  localparam logic [AW-1:0] IND_TOP2   = 12'hFDF;
  localparam logic [AW-1:0] IND_SPAN   = 12'h004;
  localparam logic [DW-1:0] IND_RD_VAL = 8'h00;  // value seen instead

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0]  PTR_RST = 12'h000;
  localparam logic [DW-1:0]  DAT_RST = 8'h00;
  localparam logic [PCW-1:0] PC_RST  = 21'h000000;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,   // ready for a new first word
    ST_MV_RD   = 3'b001,   // source read on the memory port
    ST_MV_CAP  = 3'b010,   // source data present, second word may come
    ST_MV_W2   = 3'b011,   // source held, waiting on second word
    ST_RET_NOP = 3'b100    // dead cycle while return target loads
  } xsd_state_t;

endpackage : xsd_pkg
